// ### host_model.sv
// host on the parallel slave port: drives the three strobes and the data byte.
// put itself waits for a rising edge of clk_i, so the bench may call it after either edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic       clk_i,
	output logic      [2:0] strobe_n_o,
	output logic      [7:0] data_o
);
	logic [7:0] last_q;
	initial begin
		strobe_n_o = 3'h7;
		last_q = 8'h00;
	end
	// data only while writing
	// released bus shows the inverse, so a stale byte cannot pass
	assign data_o = strobe_n_o[1] ? ~last_q : last_q;
	task automatic put(input logic [2:0] n, input logic [7:0] d);
		@(posedge clk_i);
		strobe_n_o <= n;
		last_q <= d;
	endtask
endmodule
`default_nettype wire

// ### host_strobe_decode.sv
// decodes the host's read, write and select strobes of the parallel slave port.
// assumes strobe levels are already sampled into the core clock.
`timescale 1ns/1ps
`default_nettype none
module host_strobe_decode
	import port_io_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic        ENABLE_I,
	input  wire logic [2:0]  STROBE_N_I,
	output port_io_pkg::strobe_s STROBE_O
);
	logic rd_now;
	logic wr_now;
	logic rd_prev_q;
	logic wr_prev_q;

	assign rd_now = ENABLE_I && !STROBE_N_I[PIN_SELECT] && !STROBE_N_I[PIN_READ];
	assign wr_now = ENABLE_I && !STROBE_N_I[PIN_SELECT] && !STROBE_N_I[PIN_WRITE];

	assign STROBE_O = '{rd_active: rd_now, wr_active: wr_now,
		rd_done: rd_prev_q && !rd_now, wr_done: wr_prev_q && !wr_now};

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rd_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
		end else begin
			rd_prev_q <= rd_now;
			wr_prev_q <= wr_now;
		end
	end
endmodule
`default_nettype wire

// ### port_e_f_io.sv
// two 8-bit general purpose ports with slave-port strobes, bus high byte and analog sharing.
// assumes pins are synchronous to CORE_CLK_I and the bus master follows axi4-lite.
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - In slave port mode a selected low read strobe drives the port D data register to the host.
// - In slave port mode a selected low write strobe captures host data into port D data.
// - Chip select is active low and strobes are ignored while it is high.
// - Port E pins 0 to 2 are strobe inputs only in slave port mode, else normal pins or bus.
// - In system bus mode port E pins 0 to 7 carry address/data bits 8 to 15 in order.
// - Port E pin 7 serves capture/compare channel 2 only in single-chip mode.
// - Port E inputs are Schmitt in plain or compare use, TTL in bus mode and TTL on pins 0 to 2 in slave port mode.
// - A port F direction bit of 1 makes the pin an input, 0 drives the latch onto it.
// - Port F latch accesses read and write the latched value, not the pin levels.
// - After reset port F pins 6 to 0 are inputs and read as zero.
// - Port F pins are shared with analog functions, which override digital use.
// - Outside system bus mode, setting the slave port mode bit switches port E pins 0 to 2 to strobe inputs.
// - Port I/O on bus-shared pins exists in single-chip mode, or in external memory mode when the external bus disable bit is set.
module port_e_f_io
	import port_io_pkg::*;
(
	input  wire logic                CORE_CLK_I,
	input  wire logic                RESETN_I,
	input  wire logic [ADDR_W-1:0]   S_AXI_AWADDR,
	input  wire logic                S_AXI_AWVALID,
	output logic                     S_AXI_AWREADY,
	input  wire logic [31:0]         S_AXI_WDATA,
	input  wire logic [3:0]          S_AXI_WSTRB,
	input  wire logic                S_AXI_WVALID,
	output logic                     S_AXI_WREADY,
	output logic [1:0]               S_AXI_BRESP,
	output logic                     S_AXI_BVALID,
	input  wire logic                S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0]   S_AXI_ARADDR,
	input  wire logic                S_AXI_ARVALID,
	output logic                     S_AXI_ARREADY,
	output logic [31:0]              S_AXI_RDATA,
	output logic [1:0]               S_AXI_RRESP,
	output logic                     S_AXI_RVALID,
	input  wire logic                S_AXI_RREADY,
	input  wire logic [7:0]          PORT_E_IN_I,
	output logic [7:0]               PORT_E_OUT_O,
	output logic [7:0]               PORT_E_OE_N_O,
	output logic [7:0]               PORT_E_SCHMITT_O,
	input  wire logic [7:0]          PORT_F_IN_I,
	output logic [7:0]               PORT_F_OUT_O,
	output logic [7:0]               PORT_F_OE_N_O,
	output logic [7:0]               PORT_F_ANALOG_O,
	input  wire logic [7:0]          PORT_D_IN_I,
	output logic [7:0]               PORT_D_OUT_O,
	output logic                     PORT_D_OE_N_O,
	input  wire logic [7:0]          BUS_AD_HIGH_I,
	input  wire logic                BUS_AD_DRIVE_I,
	output logic [7:0]               BUS_AD_HIGH_O,
	output logic                     BUS_MODE_O,
	input  wire logic                CAPTURE_COMPARE_CHANNEL_2_OUT_I,
	output logic                     CAPTURE_COMPARE_CHANNEL_2_IN_O,
	input  wire logic                CMP1_OUT_I,
	input  wire logic                CMP2_OUT_I
);
	reg_wr_s    wr;
	reg_rd_s    rd;
	strobe_s    strobe;
	logic [7:0] rd_data;
	logic       rd_hit;
	logic       wr_hit;

	logic [7:0] port_e_direction_q;
	logic [7:0] port_e_latch_q;
	logic [7:0] port_f_direction_q;
	logic [7:0] port_f_latch_q;
	logic [7:0] ext_bus_control_q;
	logic [7:0] slave_port_control_q;
	logic [7:0] port_d_data_q;
	logic [7:0] analog_config_q;
	logic [7:0] device_mode_q;
	logic [7:0] pe_pins_q;
	logic [7:0] pf_pins_q;
	logic [7:0] pd_pins_q;

	logic       bus_mode;
	logic       slave_mode;
	logic       capture_compare_channel_2_routed;
	logic       cmp_on;
	logic [3:0] pcfg;
	logic [2:0] cmp_mode;
	logic [7:0] f_analog;
	logic [7:0] pe_out_d;
	logic [7:0] pe_oe_n_d;
	logic [7:0] pe_schmitt_d;
	logic [7:0] pf_out_d;
	logic [7:0] pf_oe_n_d;
	logic       in_full_set;
	logic       in_full_clr;
	logic       out_full_set;
	logic       out_full_clr;
	logic       overflow_set;
	logic       overflow_clr;

	reg_bus_slave u_bus (
		.CLK_I     (CORE_CLK_I),
		.RESETN_I  (RESETN_I),
		.AWADDR_I  (S_AXI_AWADDR),
		.AWVALID_I (S_AXI_AWVALID),
		.AWREADY_O (S_AXI_AWREADY),
		.WDATA_I   (S_AXI_WDATA),
		.WSTRB_I   (S_AXI_WSTRB),
		.WVALID_I  (S_AXI_WVALID),
		.WREADY_O  (S_AXI_WREADY),
		.BRESP_O   (S_AXI_BRESP),
		.BVALID_O  (S_AXI_BVALID),
		.BREADY_I  (S_AXI_BREADY),
		.ARADDR_I  (S_AXI_ARADDR),
		.ARVALID_I (S_AXI_ARVALID),
		.ARREADY_O (S_AXI_ARREADY),
		.RDATA_O   (S_AXI_RDATA),
		.RRESP_O   (S_AXI_RRESP),
		.RVALID_O  (S_AXI_RVALID),
		.RREADY_I  (S_AXI_RREADY),
		.WR_O      (wr),
		.RD_O      (rd),
		.RD_DATA_I (rd_data),
		.RD_HIT_I  (rd_hit),
		.WR_HIT_I  (wr_hit)
	);

	host_strobe_decode u_strobe (
		.CLK_I      (CORE_CLK_I),
		.RESETN_I   (RESETN_I),
		.ENABLE_I   (slave_mode),
		.STROBE_N_I (pe_pins_q[STROBE_N-1:0]),
		.STROBE_O   (strobe)
	);

	// mode decode
	// bus owns pins unless disabled
	assign bus_mode    = device_mode_q[EXT_MEM_MODE_BIT] && !ext_bus_control_q[EXT_BUS_DISABLE_BIT];
	assign slave_mode  = !bus_mode && slave_port_control_q[SLAVE_MODE_BIT];
	assign capture_compare_channel_2_routed = !device_mode_q[EXT_MEM_MODE_BIT] && device_mode_q[CAPTURE_COMPARE_CHANNEL_2_ROUTE_BIT];
	assign pcfg        = analog_config_q[PCFG_LSB +: 4];
	assign cmp_mode    = analog_config_q[CMP_LSB +: 3];
	assign cmp_on      = cmp_mode != CMP_OFF;

	// pins sampled once; every reader sees the same level
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pe_pins_q <= '0;
			pf_pins_q <= '0;
			pd_pins_q <= '0;
		end else begin
			pe_pins_q <= PORT_E_IN_I;
			pf_pins_q <= PORT_F_IN_I;
			pd_pins_q <= PORT_D_IN_I;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < PORT_W; gi++) begin : g_pin
			if (gi < ANALOG_N) begin : g_an
				assign f_analog[gi] = ((pcfg + FIRST_CHAN + 5'(gi)) <= LAST_CHAN)
					|| (cmp_on && gi >= CMP_IN_LO)
					|| (gi == PIN_CVREF && analog_config_q[CVREF_BIT]);
			end else begin : g_dig
				assign f_analog[gi] = 1'b0;
			end
			always_comb begin
				pf_out_d[gi]  = port_f_latch_q[gi];
				pf_oe_n_d[gi] = port_f_direction_q[gi] || f_analog[gi];
				if (cmp_mode == CMP_OUTPUT && gi == PIN_C1OUT) begin
					pf_out_d[gi]  = CMP1_OUT_I;
					pf_oe_n_d[gi] = port_f_direction_q[gi];
				end else if (cmp_mode == CMP_OUTPUT && gi == PIN_C2OUT) begin
					pf_out_d[gi]  = CMP2_OUT_I;
					pf_oe_n_d[gi] = port_f_direction_q[gi];
				end
				pe_out_d[gi]     = port_e_latch_q[gi];
				pe_oe_n_d[gi]    = port_e_direction_q[gi];
				pe_schmitt_d[gi] = 1'b1;
				if (bus_mode) begin
					pe_out_d[gi]     = BUS_AD_HIGH_I[gi];
					pe_oe_n_d[gi]    = !BUS_AD_DRIVE_I;
					pe_schmitt_d[gi] = 1'b0;
				end else if (slave_mode && gi < STROBE_N) begin
					pe_oe_n_d[gi]    = 1'b1;
					pe_schmitt_d[gi] = 1'b0;
				end else if (capture_compare_channel_2_routed && gi == PIN_TOP) begin
					pe_out_d[gi] = CAPTURE_COMPARE_CHANNEL_2_OUT_I;
				end
			end
		end
	endgenerate

	// outputs come straight from flops
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			PORT_E_OUT_O     <= '0;
			PORT_E_OE_N_O    <= '1;
			PORT_E_SCHMITT_O <= '1;
			PORT_F_OUT_O     <= '0;
			PORT_F_OE_N_O    <= '1;
			PORT_F_ANALOG_O  <= '0;
			BUS_AD_HIGH_O    <= '0;
			BUS_MODE_O       <= 1'b0;
			CAPTURE_COMPARE_CHANNEL_2_IN_O        <= 1'b0;
		end else begin
			PORT_E_OUT_O     <= pe_out_d;
			PORT_E_OE_N_O    <= pe_oe_n_d;
			PORT_E_SCHMITT_O <= pe_schmitt_d;
			PORT_F_OUT_O     <= pf_out_d;
			PORT_F_OE_N_O    <= pf_oe_n_d;
			PORT_F_ANALOG_O  <= f_analog;
			BUS_AD_HIGH_O    <= bus_mode ? pe_pins_q : '0;
			BUS_MODE_O       <= bus_mode;
			CAPTURE_COMPARE_CHANNEL_2_IN_O        <= capture_compare_channel_2_routed && pe_pins_q[PIN_TOP];
		end
	end

	// selected read presents port d data
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			PORT_D_OUT_O  <= '0;
			PORT_D_OE_N_O <= 1'b1;
		end else begin
			PORT_D_OUT_O  <= port_d_data_q;
			PORT_D_OE_N_O <= !strobe.rd_active;
		end
	end

	// register read mux
	always_comb begin
		rd_hit  = 1'b1;
		rd_data = '0;
		unique case (rd.addr)
			OFS_PORT_E_DIRECTION: rd_data = port_e_direction_q;
			OFS_PORT_E_PINS:      rd_data = pe_pins_q;
			OFS_PORT_E_LATCH:     rd_data = port_e_latch_q;
			OFS_EXT_BUS_CONTROL:  rd_data = ext_bus_control_q;
			OFS_SLAVE_PORT_CTRL:  rd_data = slave_port_control_q;
			OFS_PORT_F_DIRECTION: rd_data = port_f_direction_q;
			OFS_PORT_F_PINS:      rd_data = pf_pins_q & ~f_analog;
			OFS_PORT_F_LATCH:     rd_data = port_f_latch_q;
			OFS_PORT_D_DATA:      rd_data = port_d_data_q;
			OFS_ANALOG_CONFIG:    rd_data = analog_config_q;
			OFS_DEVICE_MODE:      rd_data = device_mode_q;
			default:              rd_hit  = 1'b0;
		endcase
	end

	always_comb begin
		unique case (wr.addr)
			OFS_PORT_E_DIRECTION, OFS_PORT_E_PINS, OFS_PORT_E_LATCH,
			OFS_EXT_BUS_CONTROL, OFS_SLAVE_PORT_CTRL, OFS_PORT_F_DIRECTION,
			OFS_PORT_F_PINS, OFS_PORT_F_LATCH, OFS_PORT_D_DATA,
			OFS_ANALOG_CONFIG, OFS_DEVICE_MODE: wr_hit = 1'b1;
			default:                             wr_hit = 1'b0;
		endcase
	end

	// direction registers
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			port_e_direction_q <= RST_DIRECTION;
			port_f_direction_q <= RST_DIRECTION;
		end else if (wr.en) begin
			if (wr.addr == OFS_PORT_E_DIRECTION)
				port_e_direction_q <= wr.data;
			if (wr.addr == OFS_PORT_F_DIRECTION)
				port_f_direction_q <= wr.data;
		end
	end

	// output latches
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			port_e_latch_q <= RST_LATCH;
			port_f_latch_q <= RST_LATCH;
		end else if (wr.en) begin
			if (wr.addr == OFS_PORT_E_PINS || wr.addr == OFS_PORT_E_LATCH)
				port_e_latch_q <= wr.data;
			if (wr.addr == OFS_PORT_F_PINS || wr.addr == OFS_PORT_F_LATCH)
				port_f_latch_q <= wr.data;
		end
	end

	// mode and analog configuration; reset leaves analog on, so f pins 0 to 6 read zero
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ext_bus_control_q <= RST_CONTROL;
			analog_config_q   <= RST_CONTROL;
			device_mode_q     <= RST_CONTROL;
		end else if (wr.en) begin
			if (wr.addr == OFS_EXT_BUS_CONTROL)
				ext_bus_control_q <= wr.data & EXT_BUS_CTRL_MASK;
			if (wr.addr == OFS_ANALOG_CONFIG)
				analog_config_q <= wr.data;
			if (wr.addr == OFS_DEVICE_MODE)
				device_mode_q <= {6'h00, wr.data[CAPTURE_COMPARE_CHANNEL_2_ROUTE_BIT], wr.data[EXT_MEM_MODE_BIT]};
		end
	end

	// slave port flags; set beats clear: hardware sets of input full and overflow, the software set of output full
	assign in_full_set  = strobe.wr_done;
	assign in_full_clr  = rd.en && rd.addr == OFS_PORT_D_DATA;
	assign out_full_set = wr.en && wr.addr == OFS_PORT_D_DATA;
	assign out_full_clr = strobe.rd_done;
	assign overflow_set = strobe.wr_done && slave_port_control_q[IN_BUF_FULL_BIT];
	assign overflow_clr = wr.en && wr.addr == OFS_SLAVE_PORT_CTRL && !wr.data[IN_BUF_OVF_BIT];

	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			slave_port_control_q <= RST_CONTROL;
		end else begin
			if (wr.en && wr.addr == OFS_SLAVE_PORT_CTRL)
				slave_port_control_q[SLAVE_MODE_BIT] <= wr.data[SLAVE_MODE_BIT];
			if (in_full_set)
				slave_port_control_q[IN_BUF_FULL_BIT] <= 1'b1;
			else if (in_full_clr)
				slave_port_control_q[IN_BUF_FULL_BIT] <= 1'b0;
			if (out_full_set)
				slave_port_control_q[OUT_BUF_FULL_BIT] <= 1'b1;
			else if (out_full_clr)
				slave_port_control_q[OUT_BUF_FULL_BIT] <= 1'b0;
			if (overflow_set)
				slave_port_control_q[IN_BUF_OVF_BIT] <= 1'b1;
			else if (overflow_clr)
				slave_port_control_q[IN_BUF_OVF_BIT] <= 1'b0;
		end
	end

	// port d data register; a host write wins over a same-cycle software write
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			port_d_data_q <= RST_LATCH;
		end else if (strobe.wr_active) begin
			port_d_data_q <= pd_pins_q;
		end else if (wr.en && wr.addr == OFS_PORT_D_DATA) begin
			port_d_data_q <= wr.data;
		end
	end
endmodule
`default_nettype wire

// ### port_e_f_io_bench.sv
// self-checking bench: axi4-lite master, host model and pin resolution.
// assumes the package, the design and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module port_e_f_io_bench;
	import port_io_pkg::*;
	logic CORE_CLK_I, RESETN_I, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
	logic BUS_AD_DRIVE_I, BUS_MODE_O, CAPTURE_COMPARE_CHANNEL_2_OUT_I, CAPTURE_COMPARE_CHANNEL_2_IN_O, CMP1_OUT_I, CMP2_OUT_I, PORT_D_OE_N_O;
	logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic [7:0] PORT_E_OUT_O, PORT_E_OE_N_O, PORT_E_SCHMITT_O, PORT_F_OUT_O, PORT_F_OE_N_O;
	logic [7:0] PORT_F_ANALOG_O, PORT_D_OUT_O, BUS_AD_HIGH_I, BUS_AD_HIGH_O, e_ext, f_ext;
	wire logic [7:0] PORT_E_IN_I, PORT_F_IN_I, PORT_D_IN_I;
	wire logic [2:0] strb_n;
	int num_errors = 0;
	int tests_run = 0;
	// a pin reads what its driver puts on it, else what the outside drives
	assign PORT_E_IN_I = (~PORT_E_OE_N_O & PORT_E_OUT_O) | (PORT_E_OE_N_O & {e_ext[7:3], strb_n});
	assign PORT_F_IN_I = (~PORT_F_OE_N_O & PORT_F_OUT_O) | (PORT_F_OE_N_O & f_ext);
	port_e_f_io i_port_e_f_io (.*);
	host_model i_host_model (.clk_i(CORE_CLK_I), .strobe_n_o(strb_n), .data_o(PORT_D_IN_I));
	initial begin
		CORE_CLK_I = 1'b0;
		forever #5 CORE_CLK_I = ~CORE_CLK_I;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge CORE_CLK_I);
		@(negedge CORE_CLK_I);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw, w, ta, tw;
		aw = 1'b1;
		w = 1'b1;
		@(posedge CORE_CLK_I);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= {24'h0, d};
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		while (aw | w) begin
			@(negedge CORE_CLK_I);
			ta = aw & S_AXI_AWREADY;
			tw = w & S_AXI_WREADY;
			@(posedge CORE_CLK_I);
			if (ta) begin
				aw = 1'b0;
				S_AXI_AWVALID <= 1'b0;
			end
			if (tw) begin
				w = 1'b0;
				S_AXI_WVALID <= 1'b0;
			end
		end
		do @(negedge CORE_CLK_I); while (!S_AXI_BVALID);
		chk({6'h0, S_AXI_BRESP}, {6'h0, RESP_OKAY});
		@(posedge CORE_CLK_I);
		S_AXI_BREADY <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		@(posedge CORE_CLK_I);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do @(negedge CORE_CLK_I); while (!S_AXI_ARREADY);
		@(posedge CORE_CLK_I);
		S_AXI_ARVALID <= 1'b0;
		do @(negedge CORE_CLK_I); while (!S_AXI_RVALID);
		chk(S_AXI_RDATA[7:0], e);
		chk({6'h0, S_AXI_RRESP}, {6'h0, er});
		@(posedge CORE_CLK_I);
		S_AXI_RREADY <= 1'b0;
	endtask
	task automatic t_reset;
		@(posedge CORE_CLK_I);
		f_ext <= 8'hFF;
		settle(2);
		chk(PORT_F_OE_N_O, RST_DIRECTION);
		chk(PORT_F_ANALOG_O, 8'h7F);
		rd(OFS_PORT_F_PINS, 8'h80, RESP_OKAY);
		rd(OFS_PORT_E_DIRECTION, RST_DIRECTION, RESP_OKAY);
		rd(OFS_EXT_BUS_CONTROL, RST_CONTROL, RESP_OKAY);
		rd(OFS_SLAVE_PORT_CTRL, RST_CONTROL, RESP_OKAY);
		rd(8'h30, 8'h00, RESP_SLVERR);
		$display("reset test done");
	endtask
	task automatic t_port_f;
		wr(OFS_ANALOG_CONFIG, {1'b0, CMP_OFF, 4'hF});
		wr(OFS_PORT_F_PINS, 8'hA5);
		wr(OFS_PORT_F_DIRECTION, 8'h0F);
		@(posedge CORE_CLK_I);
		f_ext <= 8'h3C;
		settle(2);
		chk(PORT_F_ANALOG_O, 8'h00);
		chk(PORT_F_OE_N_O, 8'h0F);
		chk(PORT_F_OUT_O & ~PORT_F_OE_N_O, 8'hA0);
		rd(OFS_PORT_F_LATCH, 8'hA5, RESP_OKAY);
		rd(OFS_PORT_F_PINS, 8'hAC, RESP_OKAY);
		wr(OFS_ANALOG_CONFIG, {1'b0, CMP_OUTPUT, 4'hF});
		settle(1);
		chk(PORT_F_OUT_O, 8'hA3);
		$display("port f test done");
	endtask
	task automatic t_port_e;
		wr(OFS_PORT_E_PINS, 8'h5A);
		wr(OFS_PORT_E_DIRECTION, 8'h00);
		settle(1);
		chk(PORT_E_OE_N_O, 8'h00);
		chk(PORT_E_OUT_O, 8'h5A);
		chk(PORT_E_SCHMITT_O, 8'hFF);
		rd(OFS_PORT_E_LATCH, 8'h5A, RESP_OKAY);
		$display("port e test done");
	endtask
	task automatic t_slave;
		wr(OFS_PORT_E_DIRECTION, 8'h07);
		wr(OFS_SLAVE_PORT_CTRL, 8'h10);
		settle(1);
		chk(PORT_E_SCHMITT_O, 8'hF8);
		i_host_model.put(3'b001, 8'h3C);
		settle(3);
		i_host_model.put(3'b111, 8'h3C);
		settle(3);
		rd(OFS_SLAVE_PORT_CTRL, 8'h90, RESP_OKAY);
		rd(OFS_PORT_D_DATA, 8'h3C, RESP_OKAY);
		i_host_model.put(3'b101, 8'h55);
		settle(3);
		i_host_model.put(3'b111, 8'h55);
		rd(OFS_PORT_D_DATA, 8'h3C, RESP_OKAY);
		wr(OFS_PORT_D_DATA, 8'hC3);
		i_host_model.put(3'b010, 8'h00);
		settle(2);
		chk({7'h0, PORT_D_OE_N_O}, 8'h00);
		chk(PORT_D_OUT_O, 8'hC3);
		i_host_model.put(3'b110, 8'h00);
		settle(2);
		chk({7'h0, PORT_D_OE_N_O}, 8'h01);
		i_host_model.put(3'b111, 8'h00);
		wr(OFS_SLAVE_PORT_CTRL, 8'h00);
		$display("slave port test done");
	endtask
	task automatic t_bus;
		@(posedge CORE_CLK_I);
		BUS_AD_HIGH_I <= 8'h96;
		BUS_AD_DRIVE_I <= 1'b1;
		wr(OFS_DEVICE_MODE, 8'h01);
		settle(2);
		chk({7'h0, BUS_MODE_O}, 8'h01);
		chk(PORT_E_SCHMITT_O, 8'h00);
		chk(PORT_E_OUT_O & ~PORT_E_OE_N_O, 8'h96);
		@(posedge CORE_CLK_I);
		BUS_AD_DRIVE_I <= 1'b0;
		e_ext <= 8'hA8;
		settle(3);
		chk(BUS_AD_HIGH_O, 8'hAF);
		wr(OFS_EXT_BUS_CONTROL, 8'h80);
		wr(OFS_PORT_E_DIRECTION, 8'h87);
		wr(OFS_DEVICE_MODE, 8'h02);
		settle(2);
		chk({7'h0, BUS_MODE_O}, 8'h00);
		chk(PORT_E_OE_N_O, 8'h87);
		chk({7'h0, CAPTURE_COMPARE_CHANNEL_2_IN_O}, 8'h01);
		chk(PORT_E_OUT_O, 8'hDA);
		wr(OFS_DEVICE_MODE, 8'h03);
		settle(2);
		chk({7'h0, CAPTURE_COMPARE_CHANNEL_2_IN_O}, 8'h00);
		chk(PORT_E_OUT_O, 8'h5A);
		$display("bus and capture test done");
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
		S_AXI_WSTRB = 4'hF;
		{BUS_AD_DRIVE_I, CAPTURE_COMPARE_CHANNEL_2_OUT_I, CMP1_OUT_I, CMP2_OUT_I} = 4'h5;
		{BUS_AD_HIGH_I, e_ext, f_ext} = 24'h0;
		RESETN_I = 1'b0;
		repeat (12) @(posedge CORE_CLK_I);
		RESETN_I <= 1'b1;
		t_reset();
		t_port_f();
		t_port_e();
		t_slave();
		t_bus();
		conclude();
	end
	// all tests need well under 2000 cycles
	initial begin
		#200000;
		num_errors++;
		conclude();
	end
endmodule
`default_nettype wire

// ### port_e_f_io_checker.sv
// pin and bus timing checks for the two-port i/o block.
// assumes the bind below and the registered two-edge pin path.
`timescale 1ns/1ps
`default_nettype none
module port_e_f_io_checker (
	input wire logic       CORE_CLK_I,
	input wire logic       RESETN_I,
	input wire logic       S_AXI_BVALID,
	input wire logic       S_AXI_BREADY,
	input wire logic       S_AXI_ARVALID,
	input wire logic       S_AXI_ARREADY,
	input wire logic       S_AXI_RVALID,
	input wire logic       S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [7:0] PORT_E_IN_I,
	input wire logic [7:0] PORT_E_OUT_O,
	input wire logic [7:0] PORT_E_OE_N_O,
	input wire logic [7:0] PORT_E_SCHMITT_O,
	input wire logic       PORT_D_OE_N_O,
	input wire logic [7:0] BUS_AD_HIGH_I,
	input wire logic       BUS_AD_DRIVE_I,
	input wire logic [7:0] BUS_AD_HIGH_O,
	input wire logic       BUS_MODE_O,
	input wire logic       CAPTURE_COMPARE_CHANNEL_2_IN_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);
	rd_strobe_a: assert property (!PORT_D_OE_N_O |->
		!$past(PORT_E_IN_I[0], 2) && !$past(PORT_E_IN_I[2], 2)) else $error("read drive w/o strobe");
	cs_ignored_a: assert property ($past(PORT_E_IN_I[2], 2) |-> PORT_D_OE_N_O)
		else $error("drive while deselected");
	strobe_ttl_a: assert property (!PORT_D_OE_N_O |-> PORT_E_SCHMITT_O[2:0] == 3'h0)
		else $error("strobe pins not ttl");
	bus_ttl_a: assert property (BUS_MODE_O && $past(BUS_MODE_O) |-> PORT_E_SCHMITT_O == 8'h00)
		else $error("bus pins not ttl");
	bus_drive_a: assert property (BUS_MODE_O && $past(BUS_MODE_O) && $past(BUS_AD_DRIVE_I)
		|-> PORT_E_OUT_O == $past(BUS_AD_HIGH_I) && PORT_E_OE_N_O == 8'h00) else $error("bus drive");
	bus_sample_a: assert property (BUS_MODE_O && $past(BUS_MODE_O) && $past(BUS_MODE_O, 2)
		|-> BUS_AD_HIGH_O == $past(PORT_E_IN_I, 2)) else $error("bus sample");
	ccp_off_a: assert property (BUS_MODE_O && $past(BUS_MODE_O) |-> !CAPTURE_COMPARE_CHANNEL_2_IN_O)
		else $error("capture routed in bus mode");
	bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("bvalid dropped");
	rresp_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read answer changed");
	ar_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
endmodule
bind port_e_f_io port_e_f_io_checker i_port_e_f_io_checker (.*);
`default_nettype wire

// ### port_io_pkg.sv
// constants, register map and carriers for the two-port i/o block.
// assumes a single 100 MHz core clock and a 32-bit register bus.
package port_io_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned PORT_W = 8;

	// register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFS_PORT_E_DIRECTION = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PORT_E_PINS      = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PORT_E_LATCH     = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_EXT_BUS_CONTROL  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_SLAVE_PORT_CTRL  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PORT_F_DIRECTION = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_PORT_F_PINS      = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_PORT_F_LATCH     = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_PORT_D_DATA      = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_ANALOG_CONFIG    = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_DEVICE_MODE      = 8'h28;

	// reset values
	localparam logic [7:0] RST_DIRECTION = 8'hFF;
	localparam logic [7:0] RST_LATCH     = 8'h00;
	localparam logic [7:0] RST_CONTROL   = 8'h00;

	// external_bus_control fields
	localparam int unsigned EXT_BUS_DISABLE_BIT = 7;
	localparam logic [7:0]  EXT_BUS_CTRL_MASK   = 8'hB3;
	// slave_port_control fields
	localparam int unsigned IN_BUF_FULL_BIT  = 7;
	localparam int unsigned OUT_BUF_FULL_BIT = 6;
	localparam int unsigned IN_BUF_OVF_BIT   = 5;
	localparam int unsigned SLAVE_MODE_BIT   = 4;
	// analog_config fields
	localparam int unsigned PCFG_LSB   = 0;
	localparam int unsigned CMP_LSB    = 4;
	localparam int unsigned CVREF_BIT  = 7;
	localparam logic [2:0]  CMP_OFF    = 3'h7;
	localparam logic [2:0]  CMP_OUTPUT = 3'h5;
	// device_mode fields
	localparam int unsigned EXT_MEM_MODE_BIT = 0;
	localparam int unsigned CAPTURE_COMPARE_CHANNEL_2_ROUTE_BIT   = 1;

	// pin positions
	localparam int unsigned PIN_READ   = 0;
	localparam int unsigned PIN_WRITE  = 1;
	localparam int unsigned PIN_SELECT = 2;
	localparam int unsigned STROBE_N   = 3;
	localparam int unsigned PIN_TOP    = 7;
	localparam int unsigned PIN_C2OUT  = 1;
	localparam int unsigned PIN_C1OUT  = 2;
	localparam int unsigned PIN_CVREF  = 5;
	localparam int unsigned ANALOG_N   = 7;
	localparam logic [4:0]  FIRST_CHAN = 5'h05;
	localparam logic [4:0]  LAST_CHAN  = 5'h0E;
	localparam int unsigned CMP_IN_LO  = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic              en;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} reg_wr_s;

	typedef struct packed {
		logic              en;
		logic [ADDR_W-1:0] addr;
	} reg_rd_s;

	typedef struct packed {
		logic rd_active;
		logic wr_active;
		logic rd_done;
		logic wr_done;
	} strobe_s;

endpackage

// ### reg_bus_slave.sv
// axi4-lite slave front end turning bus transfers into one-cycle register strobes.
// assumes the register file answers reads combinationally from the read strobe address.
`timescale 1ns/1ps
`default_nettype none
module reg_bus_slave
	import port_io_pkg::*;
(
	input  wire logic                CLK_I,
	input  wire logic                RESETN_I,
	input  wire logic [ADDR_W-1:0]   AWADDR_I,
	input  wire logic                AWVALID_I,
	output logic                     AWREADY_O,
	input  wire logic [31:0]         WDATA_I,
	input  wire logic [3:0]          WSTRB_I,
	input  wire logic                WVALID_I,
	output logic                     WREADY_O,
	output logic [1:0]               BRESP_O,
	output logic                     BVALID_O,
	input  wire logic                BREADY_I,
	input  wire logic [ADDR_W-1:0]   ARADDR_I,
	input  wire logic                ARVALID_I,
	output logic                     ARREADY_O,
	output logic [31:0]              RDATA_O,
	output logic [1:0]               RRESP_O,
	output logic                     RVALID_O,
	input  wire logic                RREADY_I,
	output port_io_pkg::reg_wr_s     WR_O,
	output port_io_pkg::reg_rd_s     RD_O,
	input  wire logic [7:0]          RD_DATA_I,
	input  wire logic                RD_HIT_I,
	input  wire logic                WR_HIT_I
);
	logic              aw_held_q;
	logic              w_held_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [7:0]        w_data_q;
	logic              w_lane_q;
	logic              do_write;

	assign AWREADY_O = !aw_held_q && !BVALID_O;
	assign WREADY_O  = !w_held_q && !BVALID_O;
	assign ARREADY_O = !RVALID_O;
	assign do_write  = aw_held_q && w_held_q && !BVALID_O;
	// byte lane 0 carries all eight register bits
	assign WR_O      = '{en: do_write && w_lane_q, addr: aw_addr_q, data: w_data_q};
	assign RD_O      = '{en: ARVALID_I && ARREADY_O, addr: ARADDR_I};

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_lane_q  <= 1'b0;
			BVALID_O  <= 1'b0;
			BRESP_O   <= RESP_OKAY;
		end else begin
			if (AWVALID_I && AWREADY_O) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= AWADDR_I;
			end
			if (WVALID_I && WREADY_O) begin
				w_held_q <= 1'b1;
				w_data_q <= WDATA_I[7:0];
				w_lane_q <= WSTRB_I[0];
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				BVALID_O  <= 1'b1;
				BRESP_O   <= WR_HIT_I ? RESP_OKAY : RESP_SLVERR;
			end else if (BVALID_O && BREADY_I) begin
				BVALID_O <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			RVALID_O <= 1'b0;
			RDATA_O  <= '0;
			RRESP_O  <= RESP_OKAY;
		end else if (RD_O.en) begin
			RVALID_O <= 1'b1;
			RDATA_O  <= {24'h000000, RD_DATA_I};
			RRESP_O  <= RD_HIT_I ? RESP_OKAY : RESP_SLVERR;
		end else if (RVALID_O && RREADY_I) begin
			RVALID_O <= 1'b0;
		end
	end
endmodule
`default_nettype wire
